// ---- core/mfdt_params.svh ----
// Constants for the multi-function delay timer.
// Assumes a 100 MHz clock and one asynchronous active-low reset.
// How it works
// - Pulse-generator mode waits the preset delay after supply appears, then gives one 0.5 s output pulse and ignores the trigger.
// - Pulse-generator mode gives no second pulse until supply is removed and restored, which restarts the delay.
// - One-shot mode arms on supply, and a trigger closure energizes the output and starts the delay.
// - In one-shot mode trigger activity during the delay changes neither output nor timer.
// - One-shot mode re-arms only when the trigger is applied while the output is off.
// - On/off-delay mode starts the delay on trigger closure, then energizes the output until the trigger opens.
// - In on/off-delay and memory-latch modes, loss of supply drops the output and clears all timing and latch state.
// - Memory-latch mode toggles the output on each new trigger closure and ignores openings.
// - The supply indicator is lit whenever supply is present.
// - The output indicator blinks while a delay counts with the output de-energized and is steadily lit while the output is energized.
// - Exactly one of ten functions is selected and the output follows it.
// - The output rests de-energized in every mode while supply is absent.
`ifndef MFDT_PARAMS_SVH
`define MFDT_PARAMS_SVH

`define MFDT_CLK_HZ 100000000
`define MFDT_TICK_US 100000
// Cycles per 0.1 s timing tick
`define MFDT_TICK_CYC ((`MFDT_CLK_HZ / 1000000) * `MFDT_TICK_US)
`define MFDT_PULSE_MS 500
// Pulse length in 0.1 s ticks
`define MFDT_PULSE_TICKS ((`MFDT_PULSE_MS * 1000) / `MFDT_TICK_US)
// Blink toggles every this many ticks (0.2 s half period)
`define MFDT_BLINK_TICKS 2
`define MFDT_DELAY_W 16

`endif

// ---- core/mfdt_pkg.sv ----
// Types for the multi-function delay timer.
// Included constants come from mfdt_params.svh.
package mfdt_pkg;

   typedef enum logic [3:0]
   {
      MFDT_ON_DELAY = 4'h0,
      MFDT_REPEAT_OFF = 4'h1,
      MFDT_INTERVAL = 4'h2,
      MFDT_OFF_DELAY = 4'h3,
      MFDT_RETRIG = 4'h4,
      MFDT_REPEAT_ON = 4'h5,
      MFDT_PULSE_GEN = 4'h6,
      MFDT_ONE_SHOT = 4'h7,
      MFDT_ON_OFF = 4'h8,
      MFDT_LATCH = 4'h9
   } mfdt_func_t;

   typedef enum logic [2:0]
   {
      MFDT_IDLE = 3'b000,
      MFDT_TIMING = 3'b001,
      MFDT_ACTIVE = 3'b010,
      MFDT_PULSE = 3'b011,
      MFDT_DONE = 3'b100
   } mfdt_state_t;

endpackage : mfdt_pkg

// ---- core/mfdt_sync.sv ----
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a slow pin level, not a pulse.
`timescale 1ns/10ps
module mfdt_sync
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Level in and out
   input wire logic din,
   output logic dout
);

   logic meta_q;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end

endmodule : mfdt_sync

// ---- core/mfdt_timer.sv ----
// Timing controller for a multi-function delay relay.
// Assumes supply and trigger are clean debounced pin levels; function and
// delay settings are static while supply is present.
`timescale 1ns/10ps
`include "mfdt_params.svh"
module mfdt_timer
   import mfdt_pkg::*;
#(
   parameter int TICK_CYC = `MFDT_TICK_CYC,
   parameter int DELAY_W = `MFDT_DELAY_W
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Pins
   input wire logic supply_in,
   input wire logic trigger_in,
   // Settings: function select and delay in 0.1 s ticks
   input wire logic [3:0] func_sel,
   input wire logic [DELAY_W-1:0] delay_ticks,
   // Outputs
   output logic relay_out,
   output logic supply_led,
   output logic output_led
);

   logic supply_s;
   logic trig_s;
   logic supply_prev_q;
   logic trig_prev_q;
   logic [31:0] div_q;
   logic tick;
   logic [DELAY_W-1:0] cnt_q;
   logic [1:0] blink_cnt_q;
   logic blink_q;
   mfdt_state_t state_q;
   mfdt_func_t func_q;
   logic relay_q;

   mfdt_sync u_sync_supply
   (
      .clock(clock),
      .arst_n(arst_n),
      .din(supply_in),
      .dout(supply_s)
   );

   mfdt_sync u_sync_trig
   (
      .clock(clock),
      .arst_n(arst_n),
      .din(trigger_in),
      .dout(trig_s)
   );

   wire logic supply_rise = supply_s && !supply_prev_q;
   wire logic trig_rise = trig_s && !trig_prev_q;
   wire logic trig_fall = !trig_s && trig_prev_q;

   function automatic logic expired(input logic [DELAY_W-1:0] c,
                                    input logic [DELAY_W-1:0] lim);
      expired = (c >= lim);
   endfunction : expired

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         supply_prev_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end
      else
      begin
         supply_prev_q <= supply_s;
         trig_prev_q <= trig_s;
      end
   end

   // Tick divider restarts on supply so delays start aligned
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         div_q <= 32'h0;
      else if (!supply_s || div_q == 32'(TICK_CYC - 1))
         div_q <= 32'h0;
      else
         div_q <= div_q + 32'h1;
   end
   assign tick = supply_s && (div_q == 32'(TICK_CYC - 1));

   // Function latched when supply appears; one of ten at a time
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         func_q <= MFDT_ON_DELAY;
      else if (supply_rise)
         func_q <= (func_sel > 4'h9) ? MFDT_ON_DELAY
                   : mfdt_func_t'(func_sel);
   end

   // Main sequencer; loss of supply clears everything
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= MFDT_IDLE;
         cnt_q <= '0;
         relay_q <= 1'b0;
      end
      else if (!supply_s)
      begin
         state_q <= MFDT_IDLE;
         cnt_q <= '0;
         relay_q <= 1'b0;
      end
      else if (supply_rise)
      begin
         cnt_q <= '0;
         relay_q <= 1'b0;
         // Codes above nine start like on-delay, matching func_q
         case (func_sel)
            4'h2, 4'h5:
            begin
               state_q <= MFDT_TIMING;
               relay_q <= 1'b1;
            end
            4'h3, 4'h4, 4'h7, 4'h8, 4'h9:
               state_q <= MFDT_IDLE;
            default: state_q <= MFDT_TIMING;
         endcase
      end
      else
      begin
         if (tick && state_q != MFDT_IDLE && state_q != MFDT_DONE)
            cnt_q <= cnt_q + 1'b1;
         case (func_q)
            MFDT_ON_DELAY:
               if (state_q == MFDT_TIMING && expired(cnt_q, delay_ticks))
               begin
                  state_q <= MFDT_DONE;
                  relay_q <= 1'b1;
               end
            MFDT_INTERVAL:
               if (state_q == MFDT_TIMING && expired(cnt_q, delay_ticks))
               begin
                  state_q <= MFDT_DONE;
                  relay_q <= 1'b0;
               end
            MFDT_REPEAT_OFF, MFDT_REPEAT_ON:
               if (expired(cnt_q, delay_ticks))
               begin
                  cnt_q <= '0;
                  relay_q <= !relay_q;
               end
            MFDT_OFF_DELAY:
               if (trig_s)
               begin
                  state_q <= MFDT_ACTIVE;
                  cnt_q <= '0;
                  relay_q <= 1'b1;
               end
               else if (state_q == MFDT_ACTIVE)
                  state_q <= MFDT_TIMING;
               else if (state_q == MFDT_TIMING
                        && expired(cnt_q, delay_ticks))
               begin
                  state_q <= MFDT_IDLE;
                  relay_q <= 1'b0;
               end
            MFDT_RETRIG:
               if (trig_rise)
               begin
                  state_q <= MFDT_TIMING;
                  cnt_q <= '0;
                  relay_q <= 1'b1;
               end
               else if (state_q == MFDT_TIMING
                        && expired(cnt_q, delay_ticks))
               begin
                  state_q <= MFDT_IDLE;
                  relay_q <= 1'b0;
               end
            MFDT_PULSE_GEN:
               // Trigger never looked at here
               if (state_q == MFDT_TIMING && expired(cnt_q, delay_ticks))
               begin
                  state_q <= MFDT_PULSE;
                  cnt_q <= '0;
                  relay_q <= 1'b1;
               end
               else if (state_q == MFDT_PULSE && expired(cnt_q,
                        DELAY_W'(`MFDT_PULSE_TICKS)))
               begin
                  state_q <= MFDT_DONE;
                  relay_q <= 1'b0;
               end
            MFDT_ONE_SHOT:
               if (state_q == MFDT_IDLE && trig_rise && !relay_q)
               begin
                  state_q <= MFDT_TIMING;
                  cnt_q <= '0;
                  relay_q <= 1'b1;
               end
               else if (state_q == MFDT_TIMING
                        && expired(cnt_q, delay_ticks))
               begin
                  // Trigger ignored while timing
                  state_q <= MFDT_IDLE;
                  relay_q <= 1'b0;
               end
            MFDT_ON_OFF:
               if (!trig_s)
               begin
                  state_q <= MFDT_IDLE;
                  cnt_q <= '0;
                  relay_q <= 1'b0;
               end
               else if (trig_rise || state_q == MFDT_IDLE)
               begin
                  state_q <= MFDT_TIMING;
                  cnt_q <= '0;
               end
               else if (state_q == MFDT_TIMING
                        && expired(cnt_q, delay_ticks))
               begin
                  state_q <= MFDT_ACTIVE;
                  relay_q <= 1'b1;
               end
            MFDT_LATCH:
               if (trig_rise)
                  relay_q <= !relay_q;
            default:
               state_q <= MFDT_IDLE;
         endcase
      end
   end

   // Blink base for the output indicator
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         blink_cnt_q <= 2'h0;
         blink_q <= 1'b0;
      end
      else if (tick)
      begin
         if (blink_cnt_q == 2'(`MFDT_BLINK_TICKS - 1))
         begin
            blink_cnt_q <= 2'h0;
            blink_q <= !blink_q;
         end
         else
            blink_cnt_q <= blink_cnt_q + 2'h1;
      end
   end

   wire logic counting = (state_q == MFDT_TIMING || state_q == MFDT_PULSE)
                         && func_q != MFDT_REPEAT_OFF
                         && func_q != MFDT_REPEAT_ON
                         || ((func_q == MFDT_REPEAT_OFF
                         || func_q == MFDT_REPEAT_ON) && supply_s);

   // Indicators registered so they never glitch
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         relay_out <= 1'b0;
         supply_led <= 1'b0;
         output_led <= 1'b0;
      end
      else
      begin
         relay_out <= relay_q;
         supply_led <= supply_s;
         output_led <= relay_q || (counting && blink_q);
      end
   end

endmodule : mfdt_timer

// ---- test/mfdt_pins.sv ----
// Supply source and dry trigger contact for the timer bench.
// Bench commands reach the pins at each falling edge.
`timescale 1ns/10ps
module mfdt_pins
(
   // Clock
   input wire logic clock,
   // Bench commands
   input wire logic sup,
   input wire logic trg,
   // Pins
   output logic supply_in,
   output logic trigger_in
);
   // Contact is modelled clean since the timer expects debounced levels
   initial
   begin
      supply_in = 1'b0;
      trigger_in = 1'b0;
   end
   always @(negedge clock)
   begin
      supply_in <= sup;
      trigger_in <= trg;
   end
endmodule : mfdt_pins

// ---- test/mfdt_timer_sva.sv ----
// Port assertions for the delay timer.
// Bound to mfdt_timer; parameters follow the instance.
`timescale 1ns/10ps
module mfdt_chk
#(
   parameter int TICK_CYC = 10,
   parameter int DELAY_W = 16
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Inputs
   input wire logic supply_in,
   input wire logic trigger_in,
   input wire logic [3:0] func_sel,
   input wire logic [DELAY_W-1:0] delay_ticks,
   // Outputs
   input wire logic relay_out,
   input wire logic supply_led,
   input wire logic output_led
);
   localparam int PULSE = 5 * TICK_CYC;
   int hi_cnt;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Length of the current energized run
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         hi_cnt <= 0;
      else
         hi_cnt <= relay_out ? hi_cnt + 1 : 0;
   end
   property p_sled_on;
      supply_in [*6] |-> supply_led;
   endproperty
   a_sled_on: assert property (p_sled_on) else $error("led off");
   property p_sled_off;
      !supply_in [*6] |-> !supply_led;
   endproperty
   a_sled_off: assert property (p_sled_off) else $error("led on");
   property p_rest;
      !supply_in [*6] |-> !relay_out;
   endproperty
   a_rest: assert property (p_rest) else $error("relay on");
   property p_led_on;
      relay_out [*3] |-> output_led;
   endproperty
   a_led_on: assert property (p_led_on) else $error("output led");
   property p_pulse_len;
      $fell(relay_out) && func_sel == 4'h6 && supply_in
         |-> hi_cnt >= PULSE - 1 && hi_cnt <= PULSE + 1;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse");
   property p_pulse_once;
      $fell(relay_out) && func_sel == 4'h6 && supply_in |=> !relay_out [*8];
   endproperty
   a_pulse_once: assert property (p_pulse_once) else $error("pulse2");
   property p_latch_on;
      $rose(trigger_in) && func_sel == 4'h9 && supply_led && !relay_out
         |-> ##[1:8] relay_out;
   endproperty
   a_latch_on: assert property (p_latch_on) else $error("latch on");
   property p_latch_off;
      $rose(trigger_in) && func_sel == 4'h9 && supply_led && relay_out
         |-> ##[1:8] !relay_out;
   endproperty
   a_latch_off: assert property (p_latch_off) else $error("latch");
   property p_onoff_drop;
      (func_sel == 4'h8 && !trigger_in) [*6] |-> !relay_out;
   endproperty
   a_onoff_drop: assert property (p_onoff_drop) else $error("on");
endmodule : mfdt_chk
bind mfdt_timer mfdt_chk #(.TICK_CYC(TICK_CYC), .DELAY_W(DELAY_W))
   mfdt_chk_inst (.clock(clock), .arst_n(arst_n), .supply_in(supply_in),
   .trigger_in(trigger_in), .func_sel(func_sel),
   .delay_ticks(delay_ticks), .relay_out(relay_out),
   .supply_led(supply_led), .output_led(output_led));

// ---- test/testbench.sv ----
// Self-checking bench for the delay timer, tick cut to 10 cycles.
// Pins come from mfdt_pins; the checker is bound to the timer.
`timescale 1ns/10ps
module testbench;
   logic clock = 0, arst_n = 0, sup = 0, trg = 0;
   logic supply_in, trigger_in, relay_out, supply_led, output_led;
   logic [3:0] func_sel = 4'h0;
   logic [15:0] delay_ticks = 16'h0004;
   int miscompares = 0, check_count = 0, n;
   always #5 clock = ~clock;
   mfdt_pins mfdt_pins_inst (.clock(clock), .sup(sup), .trg(trg),
      .supply_in(supply_in), .trigger_in(trigger_in));
   mfdt_timer #(.TICK_CYC(10)) mfdt_timer_inst (.clock(clock),
      .arst_n(arst_n), .supply_in(supply_in), .trigger_in(trigger_in),
      .func_sel(func_sel), .delay_ticks(delay_ticks),
      .relay_out(relay_out), .supply_led(supply_led),
      .output_led(output_led));
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   task check(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, s, e);
      end
   endtask : check
   task cyc(input int k);
      repeat (k) @(negedge clock);
   endtask : cyc
   // Bounded wait for relay level v; n gives the cycles taken
   task wait_rel(input logic v, input int lim);
      n = 0;
      while (relay_out !== v)
      begin
         cyc(1);
         n++;
         if (n > lim)
         begin
            miscompares++;
            complete_run();
         end
      end
   endtask : wait_rel
   task hold(input logic v, input int k);
      logic bad;
      bad = 0;
      repeat (k)
      begin
         cyc(1);
         bad |= (relay_out !== v);
      end
      check(bad, 0);
   endtask : hold
   task power(input logic [3:0] f, input logic v);
      func_sel = f;
      sup = v;
      cyc(6);
   endtask : power
   task t_pulse;
      delay_ticks = 16'h0003;
      power(4'h6, 1);
      check(supply_led, 1);
      trg = 1;
      wait_rel(1, 60);
      check(n >= 15 && n <= 45, 1);
      wait_rel(0, 60);
      check(n, 50);
      trg = 0;
      hold(0, 150);
      power(4'h6, 0);
      check(supply_led, 0);
      power(4'h6, 1);
      wait_rel(1, 60);
      wait_rel(0, 60);
      power(4'h6, 0);
      $display("pulse generator test done");
   endtask : t_pulse
   task t_oneshot;
      delay_ticks = 16'h0004;
      power(4'h7, 1);
      hold(0, 20);
      trg = 1;
      wait_rel(1, 6);
      cyc(3);
      trg = 0;
      cyc(10);
      trg = 1;
      cyc(3);
      trg = 0;
      wait_rel(0, 40);
      check(n >= 14 && n <= 35, 1);
      hold(0, 20);
      trg = 1;
      cyc(3);
      trg = 0;
      cyc(10);
      trg = 1;
      cyc(8);
      check(relay_out, 1);
      trg = 0;
      wait_rel(0, 60);
      power(4'h7, 0);
      $display("one-shot test done");
   endtask : t_oneshot
   task t_onoff;
      logic p;
      int t;
      power(4'h8, 1);
      trg = 1;
      p = output_led;
      t = 0;
      repeat (30)
      begin
         cyc(1);
         t += (output_led !== p);
         p = output_led;
      end
      check(t > 0 && relay_out === 1'b0, 1);
      wait_rel(1, 30);
      hold(1, 20);
      check(output_led, 1);
      trg = 0;
      wait_rel(0, 6);
      trg = 1;
      cyc(15);
      trg = 0;
      hold(0, 60);
      trg = 1;
      wait_rel(1, 60);
      sup = 0;
      wait_rel(0, 6);
      trg = 0;
      power(4'h8, 1);
      hold(0, 60);
      power(4'h8, 0);
      $display("on/off delay test done");
   endtask : t_onoff
   task t_latch;
      power(4'h9, 1);
      trg = 1;
      wait_rel(1, 6);
      cyc(10);
      trg = 0;
      hold(1, 15);
      trg = 1;
      wait_rel(0, 6);
      cyc(10);
      trg = 0;
      cyc(10);
      trg = 1;
      wait_rel(1, 6);
      sup = 0;
      wait_rel(0, 6);
      trg = 0;
      power(4'h9, 1);
      hold(0, 20);
      power(4'h9, 0);
      $display("memory latch test done");
   endtask : t_latch
   // Out-of-range code must behave as on-delay
   task t_select;
      delay_ticks = 16'h0003;
      power(4'hf, 1);
      wait_rel(1, 60);
      check(n >= 15 && n <= 45, 1);
      hold(1, 20);
      power(4'hf, 0);
      check(relay_out, 0);
      $display("function select test done");
   endtask : t_select
   initial
   begin
      cyc(6);
      arst_n = 1;
      cyc(2);
      check(relay_out, 0);
      check(supply_led, 0);
      t_pulse();
      t_oneshot();
      t_onoff();
      t_latch();
      t_select();
      complete_run();
   end
endmodule : testbench
